// >>> port_defs.svh
// Constants for the shared-pin ports D and E
// Functional notes
// - Direction one drives pin, zero floats it
// - Reset clears all direction bits of both ports
// - Data read: latch if output, pin if input, zero if an owned port D input
// - Writes always load latch, never affect input
// - Port D pins 6..0 become analog channels
// - Selected analog pin reads zero or latch
// - Timer-owned port D pins ignore direction bits for drive
// - Pins 6/4 serve timer external clock inputs
// - SPI enable claims port E pins 7..5
// - Pin 4 is slave select unless freed
// - Edge/level select claims port E pins 3,2
// - Serial enable claims receive pin 1, transmit 0
// - Port E owned pins ignore direction for drive
// - Port E has eight latches with direction
`ifndef PORT_DEFS_SVH
`define PORT_DEFS_SVH
`define ADDR_W          16
`define DATA_W          8
`define ADDR_PORT_D_DATA 16'h0003
`define ADDR_PORT_E_DATA 16'h0008
`define ADDR_PORT_D_DIR  16'h0010
`define ADDR_PORT_E_DIR  16'h0011
`define DIR_RESET       8'h00
`define LATCH_RESET     8'h00
`define PS_EXT_CLK      3'h7
`define ADC_CH_BASE     5'h08
`define ADC_PINS        7
`define ELS_OFF         2'h0
`define PD_TIMER_A_EXT_CLOCK        6
`define PD_TIMER_B_EXT_CLOCK        4
`define PE_SCK          7
`define PE_MOSI         6
`define PE_MISO         5
`define PE_SS           4
`define PE_TACH1        3
`define PE_TACH0        2
`define PE_RX           1
`define PE_TX           0
`endif

// >>> port_types_pkg.sv
// Types shared by the port block and its bench
`include "port_defs.svh"
package port_types_pkg;
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic               wr;
    logic               rd;
  } bus_req_t;

  typedef struct packed {
    logic [`DATA_W-1:0] out;
    logic [`DATA_W-1:0] oe;
  } pad_drive_t;

  typedef struct packed {
    logic [4:0] analog_channel_select;
    logic [2:0] timer_a_prescaler_select;
    logic [2:0] timer_b_prescaler_select;
    logic       spi_enable_bit;
    logic       spi_master_select;
    logic       mode_fault_enable;
    logic [1:0] ch1_edge_level_select;
    logic [1:0] ch0_edge_level_select;
    logic       uart_enable_bit;
  } periph_ctl_t;

  typedef struct packed {
    logic       spi_serial_clock;
    logic       spi_mosi;
    logic       spi_miso;
    logic [1:0] timer_a_channel_level;
    logic [1:0] timer_a_channel_oe;
    logic       uart_tx;
  } periph_drive_t;
endpackage : port_types_pkg

// >>> shared_pin_ports_d_e.sv
// Ports D and E: latches, direction, read mux and peripheral pin sharing
`include "port_defs.svh"
module shared_pin_ports_d_e
  import port_types_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire bus_req_t      bus_req,
  output logic [`DATA_W-1:0] rd_data,
  input  wire logic [7:0]    pd_in,
  input  wire logic [7:0]    pe_in,
  output pad_drive_t         pd_pad,
  output pad_drive_t         pe_pad,
  input  wire periph_ctl_t   ctl,
  input  wire periph_drive_t per,
  output logic [7:0]         pd_level,
  output logic [7:0]         pe_level
);

  // Latch when output, pin when input, zero where a masked pin is input
  function automatic logic [7:0] port_read(input logic [7:0] ddr, input logic [7:0] lat,
                                           input logic [7:0] pin, input logic [7:0] zero);
    port_read = (ddr & lat) | (~ddr & ~zero & pin);
  endfunction : port_read

  // Which of pins 6..0 the analog channel select claims
  function automatic logic [7:0] adc_mask(input logic [4:0] sel);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < `ADC_PINS; i++) begin
      if (sel == 5'(`ADC_CH_BASE + i)) begin
        m[i] = 1'b1;
      end
    end
    adc_mask = m;
  endfunction : adc_mask

  function automatic logic ext_clk_sel(input logic [2:0] ps);
    ext_clk_sel = (ps == `PS_EXT_CLK);
  endfunction : ext_clk_sel

  logic [7:0] ddr_d_r;
  logic [7:0] ddr_e_r;
  logic [7:0] lat_d_r;
  logic [7:0] lat_e_r;
  logic [7:0] pd_meta_r;
  logic [7:0] pe_meta_r;
  logic [7:0] pd_sync_r;
  logic [7:0] pe_sync_r;

  // Register decode
  wire sel_d_data = (bus_req.addr == `ADDR_PORT_D_DATA);
  wire sel_e_data = (bus_req.addr == `ADDR_PORT_E_DATA);
  wire sel_d_dir  = (bus_req.addr == `ADDR_PORT_D_DIR);
  wire sel_e_dir  = (bus_req.addr == `ADDR_PORT_E_DIR);
  wire wr_d_data  = bus_req.wr & sel_d_data;
  wire wr_e_data  = bus_req.wr & sel_e_data;
  wire wr_d_dir   = bus_req.wr & sel_d_dir;
  wire wr_e_dir   = bus_req.wr & sel_e_dir;

  // Port D ownership
  wire [7:0] adc_own_d = adc_mask(ctl.analog_channel_select);
  wire       ta_clk    = ext_clk_sel(ctl.timer_a_prescaler_select);
  wire       tb_clk    = ext_clk_sel(ctl.timer_b_prescaler_select);
  wire [7:0] tmr_own_d = ({7'h00, ta_clk} << `PD_TIMER_A_EXT_CLOCK) | ({7'h00, tb_clk} << `PD_TIMER_B_EXT_CLOCK);
  wire [7:0] own_d     = adc_own_d | tmr_own_d;

  // Port E ownership
  wire spi_on   = ctl.spi_enable_bit;
  wire ss_own   = spi_on & ~(ctl.spi_master_select & ~ctl.mode_fault_enable);
  wire tach1_on = (ctl.ch1_edge_level_select != `ELS_OFF);
  wire tach0_on = (ctl.ch0_edge_level_select != `ELS_OFF);
  wire uart_on  = ctl.uart_enable_bit;
  wire [7:0] own_e = {spi_on, spi_on, spi_on, ss_own, tach1_on, tach0_on, uart_on, uart_on};

  // Peripheral drive of owned port E pins
  wire       mstr     = ctl.spi_master_select;
  wire [7:0] per_oe_e = {mstr, mstr, ~mstr, 1'b0, per.timer_a_channel_oe, 1'b0, 1'b1};
  wire [7:0] per_out_e = {per.spi_serial_clock, per.spi_mosi, per.spi_miso, 1'b0,
                          per.timer_a_channel_level, 1'b0, per.uart_tx};

  // Next pad drive
  wire [7:0] pd_oe_nxt  = ddr_d_r & ~own_d;
  wire [7:0] pe_oe_nxt  = (own_e & per_oe_e) | (~own_e & ddr_e_r);
  wire [7:0] pe_out_nxt = (own_e & per_out_e) | (~own_e & lat_e_r);

  // Read data, selected during the access cycle
  wire [7:0] rd_d = port_read(ddr_d_r, lat_d_r, pd_sync_r, own_d);
  wire [7:0] rd_e = port_read(ddr_e_r, lat_e_r, pe_sync_r, 8'h00);
  wire [7:0] rd_mux = sel_d_data ? rd_d :
                      sel_e_data ? rd_e :
                      sel_d_dir  ? ddr_d_r :
                      sel_e_dir  ? ddr_e_r : 8'h00;
  assign rd_data = bus_req.rd ? rd_mux : 8'h00;

  // Direction registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ddr_d_r <= `DIR_RESET;
      ddr_e_r <= `DIR_RESET;
    end else begin
      if (wr_d_dir) ddr_d_r <= bus_req.wdata;
      if (wr_e_dir) ddr_e_r <= bus_req.wdata;
    end
  end

  // Output latches, written whatever the direction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lat_d_r <= `LATCH_RESET;
      lat_e_r <= `LATCH_RESET;
    end else begin
      if (wr_d_data) lat_d_r <= bus_req.wdata;
      if (wr_e_data) lat_e_r <= bus_req.wdata;
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_meta_r <= 8'h00;
      pe_meta_r <= 8'h00;
      pd_sync_r <= 8'h00;
      pe_sync_r <= 8'h00;
    end else begin
      pd_meta_r <= pd_in;
      pe_meta_r <= pe_in;
      pd_sync_r <= pd_meta_r;
      pe_sync_r <= pe_meta_r;
    end
  end

  assign pd_level = pd_sync_r;
  assign pe_level = pe_sync_r;

  // Registered pad drive
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_pad <= '0;
      pe_pad <= '0;
    end else begin
      pd_pad.out <= lat_d_r;
      pd_pad.oe  <= pd_oe_nxt;
      pe_pad.out <= pe_out_nxt;
      pe_pad.oe  <= pe_oe_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_dir_reset_zero: assert property (@(posedge clk) disable iff (1'b0)
    !rst_b |-> (ddr_d_r == `DIR_RESET && ddr_e_r == `DIR_RESET))
    else $error("Direction bits not cleared in reset");

  a_pd_drive_dir: assert property (
    1'b1 |=> pd_pad.oe == ($past(ddr_d_r) & ~$past(own_d)))
    else $error("Port D drive does not follow direction");

  a_pd_read_mux: assert property (
    (bus_req.rd && sel_d_data && own_d == 8'h00) |->
      rd_data == ((ddr_d_r & lat_d_r) | (~ddr_d_r & pd_sync_r)))
    else $error("Port D read mux wrong");

  a_latch_write_any: assert property (
    wr_e_data |=> (lat_e_r == $past(bus_req.wdata)) && (pe_sync_r == $past(pe_meta_r)))
    else $error("Port E latch write lost");

  a_adc_read_zero: assert property (
    (bus_req.rd && sel_d_data) |-> ((rd_data & adc_own_d & ~ddr_d_r) == 8'h00)
      && ((rd_data & adc_own_d & ddr_d_r) == (lat_d_r & adc_own_d & ddr_d_r)))
    else $error("Analog pin read wrong");

  a_tclk_input_only: assert property (
    (ta_clk && tb_clk) [*2] |-> !pd_pad.oe[`PD_TIMER_A_EXT_CLOCK] && !pd_pad.oe[`PD_TIMER_B_EXT_CLOCK])
    else $error("Timer clock pin driven");

  a_spi_master_pins: assert property (
    (spi_on && mstr) |=> pe_pad.oe[`PE_SCK] && pe_pad.oe[`PE_MOSI] && !pe_pad.oe[`PE_MISO]
      && pe_pad.out[`PE_SCK] == $past(per.spi_serial_clock))
    else $error("SPI master pins wrong");

  a_ss_slave_input: assert property (
    (spi_on && !mstr) |=> !pe_pad.oe[`PE_SS])
    else $error("Slave select driven in slave mode");

  a_timer_a_channel_pin_owns_pin: assert property (
    tach1_on |=> pe_pad.oe[`PE_TACH1] == $past(per.timer_a_channel_oe[1]))
    else $error("Timer channel pin not owned");

  a_uart_tx_pin: assert property (
    uart_on |=> pe_pad.oe[`PE_TX] && !pe_pad.oe[`PE_RX] && pe_pad.out[`PE_TX] == $past(per.uart_tx))
    else $error("Serial pins wrong");

  a_pe_read_mux: assert property (
    (bus_req.rd && sel_e_data) |-> rd_data == ((ddr_e_r & lat_e_r) | (~ddr_e_r & pe_sync_r)))
    else $error("Port E read mux wrong");

  a_dir_write_next: assert property (
    wr_d_dir |=> ddr_d_r == $past(bus_req.wdata) ##1 pd_pad.oe == ($past(ddr_d_r) & ~$past(own_d)))
    else $error("Direction write not applied next edge");

  a_tclk_a_input: assert property (
    ta_clk |=> !pd_pad.oe[`PD_TIMER_A_EXT_CLOCK])
    else $error("Timer A clock pin driven");

  a_tclk_b_input: assert property (
    tb_clk |=> !pd_pad.oe[`PD_TIMER_B_EXT_CLOCK])
    else $error("Timer B clock pin driven");

  a_pd_out_latch: assert property (
    1'b1 |=> pd_pad.out == $past(lat_d_r))
    else $error("Port D pad level does not follow latch");

  a_pe_gpio_out: assert property (
    (own_e == 8'h00) |=> pe_pad.out == $past(lat_e_r))
    else $error("Port E pad level does not follow latch");

  a_pe_gpio_dir: assert property (
    (own_e == 8'h00) |=> pe_pad.oe == $past(ddr_e_r))
    else $error("Port E drive does not follow direction");

  a_spi_off_free: assert property (
    !spi_on |=> pe_pad.oe[`PE_SCK:`PE_MISO] == $past(ddr_e_r[`PE_SCK:`PE_MISO]))
    else $error("SPI pins not released");

  a_spi_slave_miso: assert property (
    (spi_on && !mstr) |=> pe_pad.oe[`PE_SCK:`PE_MISO] == 3'h1 && pe_pad.out[`PE_MISO] == $past(per.spi_miso))
    else $error("SPI slave pins wrong");

  a_spi_master_mosi: assert property (
    (spi_on && mstr) |=> pe_pad.out[`PE_MOSI] == $past(per.spi_mosi))
    else $error("SPI master data pin wrong");

  a_ss_free_pin: assert property (
    (!spi_on || (mstr && !ctl.mode_fault_enable)) |=> pe_pad.oe[`PE_SS] == $past(ddr_e_r[`PE_SS]))
    else $error("Slave select pin not free");

  a_ss_modf_input: assert property (
    (spi_on && mstr && ctl.mode_fault_enable) |=> !pe_pad.oe[`PE_SS])
    else $error("Slave select driven with fault detection");

  a_tach0_owns_pin: assert property (
    tach0_on |=> pe_pad.oe[`PE_TACH0] == $past(per.timer_a_channel_oe[0]) && pe_pad.out[`PE_TACH0] == $past(per.timer_a_channel_level[0]))
    else $error("Timer channel 0 pin not owned");

  a_tach1_out_level: assert property (
    tach1_on |=> pe_pad.out[`PE_TACH1] == $past(per.timer_a_channel_level[1]))
    else $error("Timer channel 1 level wrong");

  a_tach1_free: assert property (
    !tach1_on |=> pe_pad.oe[`PE_TACH1] == $past(ddr_e_r[`PE_TACH1]))
    else $error("Timer channel 1 pin not free");

  a_tach0_free: assert property (
    !tach0_on |=> pe_pad.oe[`PE_TACH0] == $past(ddr_e_r[`PE_TACH0]))
    else $error("Timer channel 0 pin not free");

  a_uart_free: assert property (
    !uart_on |=> pe_pad.oe[`PE_RX:`PE_TX] == $past(ddr_e_r[`PE_RX:`PE_TX]))
    else $error("Serial pins not free");

  a_adc_no_drive: assert property (
    (adc_own_d != 8'h00) |=> (pd_pad.oe & $past(adc_own_d)) == 8'h00)
    else $error("Analog pin driven");

  a_adc_pin7_free: assert property (
    !adc_own_d[7])
    else $error("Analog select claims pin 7");

  a_pd_free_dir: assert property (
    (own_d == 8'h00) |=> pd_pad.oe == $past(ddr_d_r))
    else $error("Port D free pins ignore direction");

  a_pd_read_timer: assert property (
    (bus_req.rd && sel_d_data) |-> (rd_data & tmr_own_d & ~ddr_d_r) == 8'h00)
    else $error("Timer clock pin read not zero");

  a_pd_read_input: assert property (
    (bus_req.rd && sel_d_data) |-> ((rd_data ^ pd_sync_r) & ~ddr_d_r & ~own_d) == 8'h00)
    else $error("Port D input read wrong");

  a_pe_read_latch: assert property (
    (bus_req.rd && sel_e_data) |-> ((rd_data ^ lat_e_r) & ddr_e_r) == 8'h00)
    else $error("Port E output read wrong");

  a_pd_dir_read: assert property (
    (bus_req.rd && sel_d_dir) |-> rd_data == ddr_d_r)
    else $error("Port D direction read wrong");

  a_pe_dir_read: assert property (
    (bus_req.rd && sel_e_dir) |-> rd_data == ddr_e_r)
    else $error("Port E direction read wrong");

  a_idle_read_zero: assert property (
    !bus_req.rd |-> rd_data == 8'h00)
    else $error("Read data without read strobe");

  a_unmapped_read: assert property (
    (bus_req.rd && !(sel_d_data || sel_e_data || sel_d_dir || sel_e_dir)) |-> rd_data == 8'h00)
    else $error("Unmapped read not zero");

  a_pe_dir_write: assert property (
    wr_e_dir |=> ddr_e_r == $past(bus_req.wdata))
    else $error("Port E direction write lost");

  a_pd_latch_write: assert property (
    wr_d_data |=> lat_d_r == $past(bus_req.wdata))
    else $error("Port D latch write lost");

  a_pd_dir_hold: assert property (
    !wr_d_dir |=> ddr_d_r == $past(ddr_d_r))
    else $error("Port D direction changed without write");

  a_pe_dir_hold: assert property (
    !wr_e_dir |=> ddr_e_r == $past(ddr_e_r))
    else $error("Port E direction changed without write");

  a_pd_latch_hold: assert property (
    !wr_d_data |=> lat_d_r == $past(lat_d_r))
    else $error("Port D latch changed without write");

  a_pe_latch_hold: assert property (
    !wr_e_data |=> lat_e_r == $past(lat_e_r))
    else $error("Port E latch changed without write");

  a_pd_level_sync: assert property (
    1'b1 |=> ##1 pd_level == $past(pd_in, 2))
    else $error("Port D pin level not synchronised");

  a_pe_level_sync: assert property (
    1'b1 |=> ##1 pe_level == $past(pe_in, 2))
    else $error("Port E pin level not synchronised");

  a_pads_reset_off: assert property (@(posedge clk) disable iff (1'b0)
    !rst_b |-> (pd_pad.oe == 8'h00 && pe_pad.oe == 8'h00))
    else $error("Pads driven in reset");

  c_tclk_sel:    cover property (ta_clk ##1 tb_clk);
  c_spi_slave:   cover property (spi_on && !mstr ##1 bus_req.rd && sel_e_data);
  c_adc_read:    cover property (adc_own_d != 8'h00 && bus_req.rd && sel_d_data);
  c_uart_on:     cover property (!uart_on ##1 uart_on);
  c_dir_to_out:  cover property (wr_d_data ##1 wr_d_dir);

endmodule : shared_pin_ports_d_e

// >>> port_pins_model.sv
// Board-side pin model: each pad follows the chip when driven, else the external source
module port_pins_model
  import port_types_pkg::*;
(
  input  wire pad_drive_t pd_pad,
  input  wire pad_drive_t pe_pad,
  input  wire logic [7:0] d_ext,
  input  wire logic [7:0] e_ext,
  output logic [7:0]      pd_in,
  output logic [7:0]      pe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pd_in = (pd_pad.oe & pd_pad.out) | (~pd_pad.oe & d_ext);
  assign pe_in = (pe_pad.oe & pe_pad.out) | (~pe_pad.oe & e_ext);
endmodule : port_pins_model

// >>> test_shared_pin_ports_d_e.sv
// Self-checking bench for ports D and E with a behavioural reference
`include "port_defs.svh"
module test_shared_pin_ports_d_e
  import port_types_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'b0;
  logic          rst_b = 1'b1;
  bus_req_t      bus_req = '0;
  periph_ctl_t   ctl = '0;
  periph_drive_t per = '0;
  logic [7:0]    d_ext = 8'h00;
  logic [7:0]    e_ext = 8'h00;
  logic [7:0]    rd_data, pd_in, pe_in, pd_level, pe_level;
  pad_drive_t    pd_pad, pe_pad, dx, ex;
  logic [7:0]    lat_d, lat_e, dir_d, dir_e, own, pin_d, pin_e;
  int unsigned   seed = 57;
  int unsigned   r;
  int            num_errors = 0;
  int            n_compared = 0;

  always #5 clk = ~clk;

  shared_pin_ports_d_e uut (.clk(clk), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
    .pd_in(pd_in), .pe_in(pe_in), .pd_pad(pd_pad), .pe_pad(pe_pad), .ctl(ctl), .per(per),
    .pd_level(pd_level), .pe_level(pe_level));
  port_pins_model pins (.pd_pad(pd_pad), .pe_pad(pe_pad), .d_ext(d_ext), .e_ext(e_ext),
    .pd_in(pd_in), .pe_in(pe_in));

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    check(rd_data, exp);
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(posedge clk);
  endtask : rd

  // Reference pad drive, ownership and pin levels from model state
  task automatic ref_calc();
    own = 8'h00;
    if (ctl.analog_channel_select >= `ADC_CH_BASE && ctl.analog_channel_select < `ADC_CH_BASE + `ADC_PINS)
      own[ctl.analog_channel_select - `ADC_CH_BASE] = 1'b1;
    if (ctl.timer_a_prescaler_select == `PS_EXT_CLK) own[`PD_TIMER_A_EXT_CLOCK] = 1'b1;
    if (ctl.timer_b_prescaler_select == `PS_EXT_CLK) own[`PD_TIMER_B_EXT_CLOCK] = 1'b1;
    dx = '{out: lat_d, oe: dir_d & ~own};
    ex = '{out: lat_e, oe: dir_e};
    if (ctl.spi_enable_bit) begin
      ex.oe[7:5] = ctl.spi_master_select ? 3'b110 : 3'b001;
      ex.out[7:5] = {per.spi_serial_clock, per.spi_mosi, per.spi_miso};
      if (!ctl.spi_master_select || ctl.mode_fault_enable) ex.oe[4] = 1'b0;
    end
    if (ctl.ch1_edge_level_select != `ELS_OFF) begin
      ex.oe[3] = per.timer_a_channel_oe[1];
      ex.out[3] = per.timer_a_channel_level[1];
    end
    if (ctl.ch0_edge_level_select != `ELS_OFF) begin
      ex.oe[2] = per.timer_a_channel_oe[0];
      ex.out[2] = per.timer_a_channel_level[0];
    end
    if (ctl.uart_enable_bit) begin
      ex.oe[1:0] = 2'b01;
      ex.out[0] = per.uart_tx;
    end
    pin_d = (dx.oe & dx.out) | (~dx.oe & d_ext);
    pin_e = (ex.oe & ex.out) | (~ex.oe & e_ext);
  endtask : ref_calc

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    for (int t = 0; t < 2; t++) begin
      rst_b <= 1'b0;
      ctl <= '0;
      per <= '0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      lat_d = `LATCH_RESET;
      lat_e = `LATCH_RESET;
      dir_d = `DIR_RESET;
      dir_e = `DIR_RESET;
      @(negedge clk);
      check(pd_pad.oe | pe_pad.oe, 8'h00);
      @(posedge clk);
      rd(`ADDR_PORT_D_DIR, 8'h00);
      rd(`ADDR_PORT_E_DIR, 8'h00);
      for (int i = 0; i < 40; i++) begin
        r = xs();
        wr(`ADDR_PORT_D_DATA, r[7:0]);
        wr(`ADDR_PORT_E_DATA, r[15:8]);
        wr(`ADDR_PORT_D_DIR, r[23:16]);
        wr(`ADDR_PORT_E_DIR, r[31:24]);
        {lat_d, lat_e, dir_d, dir_e} = {r[7:0], r[15:8], r[23:16], r[31:24]};
        wr(16'h0020, 8'hff);
        r = xs();
        ctl <= r[18:0];
        per <= r[26:19];
        r = xs();
        d_ext <= r[7:0];
        e_ext <= r[15:8];
        repeat (5) @(posedge clk);
        ref_calc();
        check(pd_pad.oe, dx.oe);
        check(pd_pad.out & dx.oe, dx.out & dx.oe);
        check(pe_pad.oe, ex.oe);
        check(pe_pad.out & ex.oe, ex.out & ex.oe);
        check(pd_level, pin_d);
        check(pe_level, pin_e);
        rd(`ADDR_PORT_D_DATA, (dir_d & lat_d) | (~dir_d & ~own & pin_d));
        rd(`ADDR_PORT_E_DATA, (dir_e & lat_e) | (~dir_e & pin_e));
        rd(`ADDR_PORT_D_DIR, dir_d);
        rd(`ADDR_PORT_E_DIR, dir_e);
        rd(16'h0020, 8'h00);
      end
      $display("test %0d done, mismatches %0d", t, num_errors);
    end
    wrap_up();
  end
endmodule : test_shared_pin_ports_d_e
